// [basp_pkg.sv]
/*
 package of the bridge converter serial port: register selects, command
 bits, register lengths, reset values and timing counts.
 assumes a 50 MHz system clock; the serial clock is supplied by the host.
*/
package basp_pkg;
	// system clock rate
	localparam int unsigned CLK_HZ = 50_000_000;
	// register selects carried in the communications byte
	localparam logic [2:0] SEL_STATUS = 3'h0;
	localparam logic [2:0] SEL_DATA = 3'h1;
	localparam logic [2:0] SEL_MODE = 3'h2;
	localparam logic [2:0] SEL_FILTER = 3'h3;
	localparam logic [2:0] SEL_DAC = 3'h4;
	// communications byte field positions
	localparam int ACC_HI_BIT = 5;
	localparam int ACC_LO_BIT = 4;
	// serial word lengths in clocks
	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_MODE = 5'h10;
	localparam logic [4:0] LEN_WORD = 5'h18;
	// byte that leaves continuous read
	localparam logic [7:0] CMD_CREAD_EXIT = 8'h30;
	// reset values
	localparam logic [15:0] MODE_RST = 16'h01b0;
	localparam logic [23:0] FILTER_RST = 24'h200010;
	localparam logic [7:0] DAC_RST = 8'h00;
	// mode register function field and codes
	localparam int MODE_FN_TOP = 15;
	localparam logic [2:0] FN_IDLE = 3'h0;
	localparam logic [2:0] FN_CONV = 3'h1;
	localparam logic [2:0] FN_ZERO_CAL = 3'h4;
	localparam logic [2:0] FN_FULL_CAL = 3'h5;
	// filter register chop enable position
	localparam int CHOP_BIT = 4;
	// output word rate at chop on and its period
	localparam int unsigned WORD_RATE_HZ = 50;
	localparam int unsigned WORD_CYCLES = CLK_HZ / WORD_RATE_HZ;
	// ready guard ahead of each data update, least time
	localparam int unsigned GUARD_NS = 1000;
	localparam int unsigned GUARD_CYCLES = (GUARD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// self calibration length in word periods
	localparam int unsigned CAL_WORDS = 2;
	// link side states
	typedef enum logic [3:0] {
		LK_COMM = 4'h1,
		LK_WRITE = 4'h2,
		LK_READ = 4'h4,
		LK_CREAD = 4'h8
	} basp_link_e;
	// converter side states
	typedef enum logic [2:0] {
		CV_IDLE = 3'h1,
		CV_CONV = 3'h2,
		CV_CAL = 3'h4
	} basp_conv_e;
endpackage

// [basp_serial_port.sv]
/*
 serial register port of a bridge converter, device side: communications
 byte decode, register writes, single and continuous reads, data ready.
 assumes the host owns chip select, serial clock and serial input, that
 edge_select is strapped, and that conversion words arrive on conv_data.
*/
`timescale 1ns/1ps
module basp_serial_port #(
	parameter int unsigned WORD_CYCLES = basp_pkg::WORD_CYCLES,
	parameter int unsigned CAL_CYCLES = basp_pkg::WORD_CYCLES * basp_pkg::CAL_WORDS
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic edge_select,
	output logic serial_out,
	output logic serial_out_oe,
	output logic data_ready_n,
	input wire logic [23:0] conv_data,
	output logic chop_enable,
	output logic [7:0] dac_code,
	output logic cal_busy
);
	////////////////////////////////////////////////////////////////////////
	// link side, clocked by the sampling edge of the serial clock
	// sampling clock: rising sclk when edge_select high, else falling
	logic sample_clk;
	assign sample_clk = sclk ^ ~edge_select;

	typedef struct packed {
		logic [1:0] rst_sync; // reset into link domain
		basp_pkg::basp_link_e state; // transfer phase
		logic [2:0] sel; // register chosen by last comms byte
		logic [4:0] cnt; // bits taken in this word
		logic [23:0] shin; // input shifter
		logic [23:0] shout; // output shifter, msb at top
		logic [15:0] mode; // mode register copy
		logic [23:0] filter; // filter register copy
		logic [7:0] dac; // dac register copy
		logic [23:0] dcopy; // latest data word
		logic fresh; // unread word flag for status
		logic [2:0] dtog; // data toggle sync and last
		logic wr_tog; // commit event to converter side
		logic [2:0] wr_sel; // committed target, held
		logic [23:0] wr_word; // committed value, held
		logic rd_tog; // data read complete event
	} basp_link_s;

	basp_link_s lk;
	basp_link_s next_lk;
	logic dat_tog; // converter side data toggle
	logic [23:0] dat_word; // converter side data register

	// length of a register in clocks
	function automatic logic [4:0] reg_len(input logic [2:0] sel);
		case (sel)
			basp_pkg::SEL_DATA, basp_pkg::SEL_FILTER: reg_len = basp_pkg::LEN_WORD;
			basp_pkg::SEL_MODE: reg_len = basp_pkg::LEN_MODE;
			default: reg_len = basp_pkg::LEN_BYTE;
		endcase
	endfunction

	// register contents, left aligned for msb first output
	function automatic logic [23:0] reg_value(input basp_link_s s);
		case (s.sel)
			basp_pkg::SEL_STATUS: reg_value = {s.fresh, 23'h000000};
			basp_pkg::SEL_DATA: reg_value = s.dcopy; // kept after read, reread allowed
			basp_pkg::SEL_MODE: reg_value = {s.mode, 8'h00};
			basp_pkg::SEL_FILTER: reg_value = s.filter;
			basp_pkg::SEL_DAC: reg_value = {s.dac, 16'h0000};
			default: reg_value = 24'h000000;
		endcase
	endfunction

	// link next state
	always_comb begin
		logic [23:0] word;
		logic last;
		word = {lk.shin[22:0], serial_in}; // msb first
		last = (lk.cnt == reg_len(lk.sel) - 5'h01);
		next_lk = lk;
		next_lk.rst_sync = {lk.rst_sync[0], rst_b};
		next_lk.dtog = {lk.dtog[1:0], dat_tog};
		// select low, or tied low, frames the bit
		if (!chip_select_n) begin
			next_lk.shin = word;
			next_lk.cnt = lk.cnt + 5'h01;
			case (lk.state)
				basp_pkg::LK_COMM: begin
					if (lk.cnt == basp_pkg::LEN_BYTE - 5'h01) begin
						next_lk.cnt = 5'h00;
						next_lk.sel = word[2:0];
						next_lk.shout = reg_value('{default: '0, sel: word[2:0],
							fresh: lk.fresh, dcopy: lk.dcopy, mode: lk.mode,
							filter: lk.filter, dac: lk.dac, state: lk.state});
						case ({word[basp_pkg::ACC_HI_BIT], word[basp_pkg::ACC_LO_BIT]})
							2'b00: next_lk.state = basp_pkg::LK_WRITE;
							2'b01: next_lk.state = basp_pkg::LK_READ;
							2'b10: next_lk.state = basp_pkg::LK_CREAD;
							default: next_lk.state = basp_pkg::LK_COMM;
						endcase
					end
				end
				basp_pkg::LK_WRITE: begin
					// commit only at the register's exact length
					if (last) begin
						next_lk.cnt = 5'h00;
						next_lk.state = basp_pkg::LK_COMM;
						next_lk.wr_tog = ~lk.wr_tog;
						next_lk.wr_sel = lk.sel;
						next_lk.wr_word = word;
						case (lk.sel)
							basp_pkg::SEL_MODE: next_lk.mode = word[15:0];
							basp_pkg::SEL_FILTER: next_lk.filter = word;
							basp_pkg::SEL_DAC: next_lk.dac = word[7:0];
							default: next_lk.wr_tog = lk.wr_tog;
						endcase
					end
				end
				basp_pkg::LK_READ: begin
					if (last) begin
						next_lk.cnt = 5'h00;
						next_lk.state = basp_pkg::LK_COMM;
						if (lk.sel == basp_pkg::SEL_DATA) begin
							next_lk.rd_tog = ~lk.rd_tog;
							next_lk.fresh = 1'b0;
						end
					end
				end
				basp_pkg::LK_CREAD: begin
					// input still watched while output runs
					if (lk.cnt == basp_pkg::LEN_BYTE - 5'h01
						&& word[7:0] == basp_pkg::CMD_CREAD_EXIT) begin
						next_lk.cnt = 5'h00;
						next_lk.state = basp_pkg::LK_COMM;
					end else if (last) begin
						next_lk.cnt = 5'h00;
						next_lk.shout = reg_value(lk); // reload for next word
						if (lk.sel == basp_pkg::SEL_DATA) begin
							next_lk.rd_tog = ~lk.rd_tog;
							next_lk.fresh = 1'b0;
						end
					end
				end
				default: next_lk.state = basp_pkg::LK_COMM;
			endcase
		end
		// new data word seen on converter side; after the read clear, so set wins
		if (lk.dtog[2] != lk.dtog[1]) begin
			next_lk.dcopy = dat_word;
			next_lk.fresh = 1'b1;
		end
		// link reset: wait for communications byte
		if (!lk.rst_sync[1]) begin
			next_lk.state = basp_pkg::LK_COMM;
			next_lk.cnt = 5'h00;
			next_lk.mode = basp_pkg::MODE_RST;
			next_lk.filter = basp_pkg::FILTER_RST;
			next_lk.dac = basp_pkg::DAC_RST;
			next_lk.fresh = 1'b0;
			next_lk.wr_tog = 1'b0; // matches cleared converter side sync
			next_lk.rd_tog = 1'b0; // matches cleared converter side sync
		end
	end

	// link register
	always_ff @(posedge sample_clk) begin
		lk <= next_lk;
	end

	// launch index: bits sampled so far, taken on the launch edge
	logic [4:0] launch_idx;
	always_ff @(negedge sample_clk) begin
		launch_idx <= lk.cnt;
	end

	// before any sample the msb stands, so select fall shows it
	logic [4:0] out_idx;
	assign out_idx = (lk.cnt == 5'h00) ? 5'h00 : launch_idx;
	assign serial_out = lk.shout[5'd23 - out_idx];
	// driven only while selected and reading
	assign serial_out_oe = !chip_select_n
		&& (lk.state == basp_pkg::LK_READ || lk.state == basp_pkg::LK_CREAD);
	assign dac_code = lk.dac;

	a_link_commit: assert property (@(posedge sample_clk) disable iff (!lk.rst_sync[1])
		(!chip_select_n && lk.state == basp_pkg::LK_WRITE
		&& lk.cnt == reg_len(lk.sel) - 5'h01) |=> lk.state == basp_pkg::LK_COMM)
		else $error("write did not commit at register length");
	a_cread_exit: assert property (@(posedge sample_clk) disable iff (!lk.rst_sync[1])
		(!chip_select_n && lk.state == basp_pkg::LK_CREAD && lk.cnt == 5'h07
		&& {lk.shin[6:0], serial_in} == basp_pkg::CMD_CREAD_EXIT)
		|=> lk.state == basp_pkg::LK_COMM)
		else $error("continuous read not left on exit byte");
	a_read_load: assert property (@(posedge sample_clk) disable iff (!lk.rst_sync[1])
		(!chip_select_n && lk.state == basp_pkg::LK_COMM && lk.cnt == 5'h07
		&& !serial_in && lk.shin[4:0] == 5'h09)
		|=> lk.state == basp_pkg::LK_READ && lk.shout == {lk.mode, 8'h00})
		else $error("mode read did not load output shifter");

	////////////////////////////////////////////////////////////////////////
	// converter side, system clock
	typedef struct packed {
		basp_pkg::basp_conv_e state; // converter activity
		logic [31:0] timer; // cycles in current word or calibration
		logic [2:0] wr_sync; // commit toggle sync and last
		logic [2:0] rd_sync; // read toggle sync and last
		logic ready_n; // data ready pin level
		logic dtog; // new data event to link
		logic [23:0] data; // data register
		logic chop; // chop from filter register
	} basp_conv_s;

	basp_conv_s cv;
	basp_conv_s next_cv;

	// converter next state
	always_comb begin
		logic wr_ev;
		logic rd_ev;
		logic [2:0] fn;
		wr_ev = cv.wr_sync[2] != cv.wr_sync[1];
		rd_ev = cv.rd_sync[2] != cv.rd_sync[1];
		fn = lk.wr_word[basp_pkg::MODE_FN_TOP -: 3];
		next_cv = cv;
		next_cv.wr_sync = {cv.wr_sync[1:0], lk.wr_tog};
		next_cv.rd_sync = {cv.rd_sync[1:0], lk.rd_tog};
		next_cv.timer = cv.timer + 32'h00000001;
		// completed data register read releases ready
		if (rd_ev) begin
			next_cv.ready_n = 1'b1;
		end
		case (cv.state)
			basp_pkg::CV_CONV: begin
				if (cv.timer == WORD_CYCLES - basp_pkg::GUARD_CYCLES - 1) begin
					next_cv.ready_n = 1'b1;
				end
				if (cv.timer == WORD_CYCLES - 1) begin
					next_cv.timer = 32'h00000000;
					next_cv.data = conv_data;
					next_cv.dtog = ~cv.dtog;
					next_cv.ready_n = 1'b0; // set wins over read release
				end
			end
			basp_pkg::CV_CAL: begin
				if (cv.timer == CAL_CYCLES - 1) begin
					next_cv.state = basp_pkg::CV_IDLE;
					next_cv.ready_n = 1'b0;
				end
			end
			default: next_cv.state = basp_pkg::CV_IDLE;
		endcase
		// mode and filter writes steer the converter
		if (wr_ev && lk.wr_sel == basp_pkg::SEL_FILTER) begin
			next_cv.chop = lk.wr_word[basp_pkg::CHOP_BIT];
		end
		if (wr_ev && lk.wr_sel == basp_pkg::SEL_MODE) begin
			next_cv.timer = 32'h00000000;
			next_cv.ready_n = 1'b1;
			case (fn)
				basp_pkg::FN_CONV: next_cv.state = basp_pkg::CV_CONV;
				basp_pkg::FN_FULL_CAL, basp_pkg::FN_ZERO_CAL: next_cv.state = basp_pkg::CV_CAL;
				default: next_cv.state = basp_pkg::CV_IDLE;
			endcase
		end
		if (!rst_b) begin
			next_cv = '0;
			next_cv.state = basp_pkg::CV_IDLE;
			next_cv.ready_n = 1'b1;
			next_cv.chop = basp_pkg::FILTER_RST[basp_pkg::CHOP_BIT];
		end
	end

	// converter register
	always_ff @(posedge clock) begin
		cv <= next_cv;
	end

	// held data word read by link side only after its toggle is synced
	assign dat_tog = cv.dtog;
	assign dat_word = cv.data;
	assign data_ready_n = cv.ready_n;
	assign chop_enable = cv.chop;
	assign cal_busy = (cv.state == basp_pkg::CV_CAL);

	a_ready_fresh: assert property (@(posedge clock) disable iff (!rst_b)
		$changed(cv.dtog) |-> !data_ready_n)
		else $error("ready not low with fresh word");
	a_ready_guard: assert property (@(posedge clock) disable iff (!rst_b)
		(cv.state == basp_pkg::CV_CONV && cv.timer == WORD_CYCLES - 1)
		|-> data_ready_n)
		else $error("ready not high before update");
	a_ready_release: assert property (@(posedge clock) disable iff (!rst_b)
		(cv.rd_sync[2] != cv.rd_sync[1] && cv.state != basp_pkg::CV_CONV
		&& !(cv.state == basp_pkg::CV_CAL && cv.timer == CAL_CYCLES - 1))
		|=> data_ready_n)
		else $error("ready not released after read");
	a_cal_start: assert property (@(posedge clock) disable iff (!rst_b)
		(cv.wr_sync[2] != cv.wr_sync[1] && lk.wr_sel == basp_pkg::SEL_MODE
		&& lk.wr_word[15:13] == basp_pkg::FN_FULL_CAL) |=> cal_busy ##1 cal_busy)
		else $error("calibration did not start");
	a_cal_idle: assert property (@(posedge clock) disable iff (!rst_b)
		(cv.state == basp_pkg::CV_CAL && cv.timer == CAL_CYCLES - 1
		&& cv.wr_sync[2] == cv.wr_sync[1])
		|=> cv.state == basp_pkg::CV_IDLE && !data_ready_n)
		else $error("calibration did not end in idle");
	a_out_off: assert property (@(posedge clock) disable iff (!rst_b)
		chip_select_n |-> !serial_out_oe)
		else $error("output driven while deselected");
endmodule

// [basp_host.sv]
/*
 host serial master model: framed transfers, msb first, both clock polarities.
 assumes edge_select is shared with the device and data lines are separate.
*/
`timescale 1ns/1ps
module basp_host (
	output logic sclk,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic edge_select
);
	logic three_wire; // select kept low, clocks frame the words
	logic head; // output level seen before any clock edge
	////////////////////////////////////////////////////////////
	// idle state at time zero
	initial begin
		sclk = 1'b1;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
		three_wire = 1'b0;
		head = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// one frame of n bits; never ties input to output
	task automatic frame(input logic [23:0] wd, input int n, output logic [23:0] rd);
		rd = 24'h000000;
		sclk = edge_select; // clock parked at its idle level
		chip_select_n = 1'b0;
		#37;
		head = (serial_out_oe === 1'b1) ? serial_out : 1'bz;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = ~edge_select; // launch edge moves the input bit
			serial_in = wd[i]; // msb set up before first sampling edge
			#80;
			sclk = edge_select; // sampling edge, device bit captured
			rd = {rd[22:0], (serial_out_oe === 1'b1) ? serial_out : ~rd[0]};
			#80;
		end
		serial_in = 1'b0; // low between words keeps continuous read
		#37;
		chip_select_n = ~three_wire;
		#43;
	endtask
	// clocks with select high, no bits taken by the device
	task automatic idle(input int n);
		chip_select_n = 1'b1;
		repeat (n) begin
			sclk = ~edge_select;
			#80;
			sclk = edge_select;
			#80;
		end
	endtask
endmodule

// [tb_top.sv]
/*
 self-checking bench of the serial port: writes, reads, calibration, ready.
 assumes basp_pkg, basp_serial_port and basp_host are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned WC = 400; // short word period
	localparam int unsigned CC = 800; // short calibration
	logic clock, rst_b, edge_select, sclk, chip_select_n, serial_in;
	logic serial_out, serial_out_oe, data_ready_n, chop_enable, cal_busy;
	logic [23:0] conv_data, rd, x;
	logic [7:0] dac_code;
	int fails, compares, seed, cnt;
	////////////////////////////////////////////////////////////
	basp_serial_port #(.WORD_CYCLES(WC), .CAL_CYCLES(CC)) i_basp_serial_port (
		.clock(clock), .rst_b(rst_b), .sclk(sclk), .chip_select_n(chip_select_n),
		.serial_in(serial_in), .edge_select(edge_select), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .data_ready_n(data_ready_n),
		.conv_data(conv_data), .chop_enable(chop_enable), .dac_code(dac_code),
		.cal_busy(cal_busy));
	basp_host i_basp_host (.sclk(sclk), .chip_select_n(chip_select_n),
		.serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .edge_select(edge_select));
	// system clock
	always #10 clock = ~clock;
	////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// value compare
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// read word compare, also the level shown before the first edge
	task automatic chk_rd(input int n, input logic [23:0] e);
		chk(rd, e);
		chk(i_basp_host.head, e[n-1]);
	endtask
	// communications byte from access bits and select
	function automatic logic [7:0] cb(input logic [1:0] acc, input logic [2:0] sel);
		return {2'b00, acc, 1'b0, sel};
	endfunction
	// register write: comms byte then n bits
	task automatic wr(input logic [2:0] sel, input logic [23:0] d, input int n);
		i_basp_host.frame({16'h0000, cb(2'b00, sel)}, 8, rd);
		i_basp_host.frame(d, n, rd);
		repeat (6) @(negedge clock);
	endtask
	// register read of n bits into rd
	task automatic rdw(input logic [2:0] sel, input int n);
		i_basp_host.frame({16'h0000, cb(2'b01, sel)}, 8, rd);
		i_basp_host.frame(24'h000000, n, rd);
		repeat (6) @(negedge clock);
	endtask
	// bounded wait for a ready level, clocks counted
	task automatic wait_rdy(input logic lvl, input int lim);
		cnt = 0;
		while (data_ready_n !== lvl && cnt < lim) begin
			@(negedge clock);
			cnt++;
		end
		chk(data_ready_n, lvl);
	endtask
	// reset with strap, outputs checked while held; link side needs sampling edges
	task automatic do_reset(input logic es);
		rst_b <= 1'b0;
		edge_select <= es;
		@(posedge clock);
		i_basp_host.idle(3);
		@(negedge clock);
		chk({serial_out_oe, data_ready_n, cal_busy, chop_enable}, 4'b0101);
		@(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		i_basp_host.idle(3);
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		edge_select = 1'b1;
		conv_data = 24'h000000;
		fails = 0;
		compares = 0;
		seed = 32'h117a134e;
		do_reset(1'b1);
		chk(dac_code, basp_pkg::DAC_RST);
		// dac held back until the eighth bit
		x = 24'($random(seed));
		i_basp_host.frame({16'h0000, cb(2'b00, basp_pkg::SEL_DAC)}, 8, rd);
		i_basp_host.frame({17'h00000, x[7:1]}, 7, rd);
		chk(dac_code, basp_pkg::DAC_RST);
		i_basp_host.frame({23'h000000, x[0]}, 1, rd);
		chk(dac_code, x[7:0]);
		// chop off then on, read back
		for (int k = 0; k < 2; k++) begin
			x = 24'($random(seed));
			x[basp_pkg::CHOP_BIT] = 1'b0;
			if (k == 1)
				x = 24'h800010;
			wr(basp_pkg::SEL_FILTER, x, 24);
			chk(chop_enable, x[basp_pkg::CHOP_BIT]);
			rdw(basp_pkg::SEL_FILTER, 24);
			chk_rd(24, x);
		end
		rdw(basp_pkg::SEL_MODE, 16);
		chk_rd(16, basp_pkg::MODE_RST);
		// full scale then zero scale calibration
		for (int k = 0; k < 2; k++) begin
			wr(basp_pkg::SEL_MODE, (k == 0) ? 24'h00b180 : 24'h009180, 16);
			chk({cal_busy, data_ready_n}, 2'b11);
			wait_rdy(1'b0, CC + 100);
			chk(24'(cnt > CC - 20), 24'h000001);
		end
		repeat (2 * WC) @(negedge clock);
		chk({cal_busy, data_ready_n}, 2'b00);
		rdw(basp_pkg::SEL_DATA, 24);
		chk(data_ready_n, 1'b1);
		// conversions: fresh word, reread, guard before update
		@(posedge clock);
		conv_data <= 24'($random(seed));
		wr(basp_pkg::SEL_MODE, 24'h002180, 16);
		wait_rdy(1'b0, 2 * WC);
		rdw(basp_pkg::SEL_STATUS, 8);
		chk_rd(8, 24'h000080);
		rdw(basp_pkg::SEL_DATA, 24);
		chk_rd(24, conv_data);
		chk(data_ready_n, 1'b1);
		rdw(basp_pkg::SEL_DATA, 24);
		chk_rd(24, conv_data);
		wait_rdy(1'b0, 2 * WC);
		wait_rdy(1'b1, 2 * WC);
		wait_rdy(1'b0, 2 * WC);
		chk(24'(cnt >= basp_pkg::GUARD_CYCLES), 24'h000001);
		// continuous read of a new word, then exit
		@(posedge clock);
		conv_data <= 24'($random(seed));
		wait_rdy(1'b1, 2 * WC);
		wait_rdy(1'b0, 2 * WC);
		i_basp_host.frame({16'h0000, cb(2'b10, basp_pkg::SEL_DATA)}, 8, rd);
		for (int k = 0; k < 2; k++) begin
			i_basp_host.frame(24'h000000, 24, rd);
			chk(rd, conv_data);
		end
		i_basp_host.frame({16'h0000, basp_pkg::CMD_CREAD_EXIT}, 8, rd);
		x = 24'($random(seed));
		wr(basp_pkg::SEL_DAC, x, 8);
		chk(dac_code, x[7:0]);
		// three wire: select never rises
		i_basp_host.three_wire = 1'b1;
		x = 24'($random(seed));
		wr(basp_pkg::SEL_DAC, x, 8);
		chk(dac_code, x[7:0]);
		rdw(basp_pkg::SEL_DAC, 8);
		chk_rd(8, {16'h0000, x[7:0]});
		i_basp_host.three_wire = 1'b0;
		// opposite clock polarity
		do_reset(1'b0);
		x = 24'($random(seed));
		wr(basp_pkg::SEL_DAC, x, 8);
		chk(dac_code, x[7:0]);
		rdw(basp_pkg::SEL_DAC, 8);
		chk_rd(8, {16'h0000, x[7:0]});
		rdw(basp_pkg::SEL_FILTER, 24);
		chk_rd(24, basp_pkg::FILTER_RST);
		end_of_test();
	end
	// hang guard, well beyond the expected run
	initial begin
		#1500000;
		fails++;
		end_of_test();
	end
endmodule
